// ### bench/ufh_serial_peer.sv
`timescale 1ns/1ps
module ufh_serial_peer (
  input  wire logic core_clk, // Clock
  input  wire logic tick16,   // 16x tick
  output logic      line      // Serial data to the device, idle high
);
  initial line = 1'b1;
  // Bit 0 of f first, each held t ticks; a short t makes a glitch
  task automatic send_bits(input logic [9:0] f, input int n, input int t);
    for (int i = 0; i < n; i++) begin
      line <= f[i];
      repeat (t) @(posedge core_clk iff tick16);
    end
  endtask
endmodule

// ### bench/ufh_uart_props.sv
`timescale 1ns/1ps
module ufh_uart_props (
  input wire logic       core_clk,          // Clock
  input wire logic       rst,               // Reset
  input wire logic [2:0] host_addr,         // Select
  input wire logic       host_cs,           // Chip select
  input wire logic       host_rd,           // Read
  input wire logic       host_wr,           // Write
  input wire logic [7:0] host_data_bus_in,  // Write data
  input wire logic [7:0] host_data_bus_out, // Read data
  input wire logic       host_data_bus_oe,  // Read enable
  input wire logic       irq,               // Interrupt
  input wire logic       tx_ready_n,        // Tx pin
  input wire logic       rx_ready_n         // Rx pin
);
  logic [5:0] shadow_reg;
  logic [5:0] shadow_next;
  wire        rd_go = host_cs && host_rd;
  wire        mode1 = shadow_reg[1] && shadow_reg[0];
  // Mask, enable and mode as last written, so pin checks know the scheme in force
  assign shadow_next = !(host_cs && host_wr) ? shadow_reg
    : host_addr == 3'h1 ? {host_data_bus_in[3:0], shadow_reg[1:0]} : host_addr != 3'h2 ? shadow_reg
    : {shadow_reg[5:2], host_data_bus_in[0], host_data_bus_in[0] ? host_data_bus_in[3] : shadow_reg[0]};
  always_ff @(posedge core_clk or posedge rst)
    if (rst) shadow_reg <= 6'h00;
    else shadow_reg <= shadow_next;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_oe_on_read: assert property (rd_go |=> host_data_bus_oe) else $error("no oe");
  a_oe_only_read: assert property (!rd_go |=> !host_data_bus_oe) else $error("oe set");
  a_mask_high_zero: assert property (rd_go && host_addr == 3'h1 |=>
    host_data_bus_out[7:4] == 4'h0) else $error("mask high bits set");
  a_irq_needs_mask: assert property (irq |-> |shadow_reg[5:2]) else $error("irq");
  a_status_fifo_bits: assert property (rd_go && host_addr == 3'h2 |=>
    host_data_bus_out[7:4] == {{2{$past(shadow_reg[1])}}, 2'h0}) else $error("status high");
  a_status_idle_code: assert property (rd_go && host_addr == 3'h2 |=>
    host_data_bus_out[0] == !$past(irq)) else $error("status pending bit");
  a_rx_pin_ready: assert property (rd_go && host_addr == 3'h5 && !mode1 |=>
    host_data_bus_out[0] == !$past(rx_ready_n)) else $error("data ready vs pin");
  a_tx_pin_empty: assert property (rd_go && host_addr == 3'h5 && !mode1 |=>
    host_data_bus_out[5] == !$past(tx_ready_n)) else $error("holding empty vs pin");
  c_status_busy: cover property (rd_go && host_addr == 3'h2 && irq);
  c_mode1_rx: cover property (mode1 && !rx_ready_n);
  c_mode1_full: cover property (mode1 && tx_ready_n);
endmodule
bind ufh_uart ufh_uart_props u_props (.core_clk, .rst, .host_addr, .host_cs, .host_rd, .host_wr,
  .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe, .irq, .tx_ready_n, .rx_ready_n);

// ### bench/ufh_uart_tb.sv
`timescale 1ns/1ps
module ufh_uart_tb;
  logic        core_clk = 1'b0, rst = 1'b1, host_cs = 1'b0, host_rd = 1'b0, host_wr = 1'b0;
  logic        tick16 = 1'b0, modem_event = 1'b0;
  logic [2:0]  host_addr = 3'h0;
  logic [7:0]  host_data_bus_in = 8'h00;
  logic [7:0]  host_data_bus_out;
  logic        host_data_bus_oe, rx_line, tx_line, irq, tx_ready_n, rx_ready_n;
  int          miscompares = 0;
  int          checked = 0;
  int          lv [4] = '{1, 4, 8, 14};
  // Rows: {write, addr, data or expected read}
  logic [11:0] rows [13] = '{12'h560, 12'h201, 12'hac1, 12'h2c1, 12'ha0e, 12'h201, 12'h300,
    12'h9ff, 12'h10f, 12'h90a, 12'h10a, 12'h202, 12'h900};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) tick16 <= ~tick16;
  ufh_uart dut (.core_clk, .rst, .host_addr, .host_cs, .host_rd, .host_wr, .host_data_bus_in,
    .host_data_bus_out, .host_data_bus_oe, .tick16, .rx_line, .tx_line, .modem_event,
    .irq, .tx_ready_n, .rx_ready_n);
  ufh_serial_peer peer (.core_clk, .tick16, .line(rx_line));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp) miscompares++;
  endtask
  // Reads compare against d; strobes held exactly one cycle
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {host_cs, host_wr, host_rd, host_addr, host_data_bus_in} <= {1'b1, w, !w, a, d};
    @(posedge core_clk);
    {host_cs, host_wr, host_rd} <= 3'h0;
    #1;
    if (!w) chk(host_data_bus_out, d);
  endtask
  task automatic grab(input logic [7:0] exp);
    logic [9:0] f;
    for (int n = 0; n < 400 && tx_line !== 1'b0; n++) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (i == 0 ? 8 : 16) @(posedge core_clk iff tick16);
      f[i] = tx_line;
    end
    chk(f[8:1], exp);
    chk({6'h0, f[9], f[0]}, 8'h02);
  endtask
  task automatic summarize();
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk({5'h0, irq, tx_ready_n, rx_ready_n}, 8'h01);
    foreach (rows[i]) bus(rows[i][11], rows[i][10:8], rows[i][7:0]);
    bus(1'b1, 3'h0, 8'ha5);
    bus(1'b1, 3'h0, 8'h3c);
    chk(8'(tx_ready_n), 8'h01);
    grab(8'ha5);
    grab(8'h3c);
    bus(1'b1, 3'h1, 8'h01);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 3'h2, {2'(c), 6'h03});
      for (int j = 1; j <= lv[c]; j++) begin
        chk(8'(irq), 8'h00);
        peer.send_bits({1'b1, 8'(j), 1'b0}, 10, 16);
      end
      chk(8'(irq), 8'h01);
    end
    bus(1'b0, 3'h2, 8'hc4);
    bus(1'b0, 3'h0, 8'h01);
    chk(8'(irq), 8'h00);
    bus(1'b0, 3'h2, 8'hc1);
    bus(1'b1, 3'h2, 8'hc3);
    peer.send_bits(10'h3fe, 2, 4);
    repeat (170) @(posedge core_clk iff tick16);
    bus(1'b0, 3'h5, 8'h60);
    bus(1'b1, 3'h2, 8'h09);
    chk({6'h0, tx_ready_n, rx_ready_n}, 8'h01);
    peer.send_bits({1'b1, 8'h5a, 1'b0}, 10, 16);
    chk(8'(rx_ready_n), 8'h00);
    bus(1'b0, 3'h0, 8'h5a);
    // The pin follows a register, so it lets go a cycle after the pop
    repeat (2) @(posedge core_clk);
    chk(8'(rx_ready_n), 8'h01);
    // Stop bit held low, then a resting byte below the trigger times out
    bus(1'b1, 3'h2, 8'h89);
    peer.send_bits({1'b0, 8'h11, 1'b0}, 10, 16);
    peer.send_bits(10'h3ff, 1, 1);
    chk(8'(rx_ready_n), 8'h01);
    repeat (660) @(posedge core_clk iff tick16);
    chk(8'(rx_ready_n), 8'h00);
    bus(1'b0, 3'h5, 8'he9);
    bus(1'b0, 3'h2, 8'hcc);
    bus(1'b0, 3'h0, 8'h11);
    repeat (17) bus(1'b1, 3'h0, 8'h77);
    chk(8'(tx_ready_n), 8'h01);
    bus(1'b1, 3'h2, 8'h0d);
    chk(8'(tx_ready_n), 8'h00);
    bus(1'b0, 3'h5, 8'h20);
    bus(1'b1, 3'h1, 8'h08);
    @(posedge core_clk) modem_event <= 1'b1;
    bus(1'b0, 3'h2, 8'hc0);
    chk(8'(irq), 8'h01);
    @(posedge core_clk) modem_event <= 1'b0;
    bus(1'b0, 3'h2, 8'hc1);
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk({5'h0, irq, tx_ready_n, rx_ready_n}, 8'h01);
    bus(1'b0, 3'h1, 8'h00);
    bus(1'b0, 3'h5, 8'h60);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
endmodule

// ### hdl/ufh_fifo.sv
`timescale 1ns/1ps
module ufh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,  // System clock
  input wire logic rst,       // Asynchronous reset, active high
  ufh_fifo_if.store fq        // Queue ports
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;

  wire push = fq.in_valid & fq.in_ready;
  wire pop  = fq.out_valid & fq.out_ready;
  wire [AW-1:0] wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
  wire [AW-1:0] rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;

  assign fq.in_ready  = (count_reg != CW'(DEPTH));
  assign fq.out_valid = (count_reg != '0);
  assign fq.out_data  = mem_reg[rd_ptr_reg];
  assign fq.count     = count_reg;

  // Flush drops contents and pointers only; a write in the same cycle is lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (fq.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_next;
      if (pop)  rd_ptr_reg <= rd_ptr_next;
      if (push && !pop) count_reg <= count_reg + 1'b1;
      else if (pop && !push) count_reg <= count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push && !fq.flush) mem_reg[wr_ptr_reg] <= fq.in_data;
  end
endmodule

// ### hdl/ufh_fifo_if.sv
`timescale 1ns/1ps
interface ufh_fifo_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
);
  localparam int CW = $clog2(DEPTH + 1);

  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic [CW-1:0]    count;
  logic             flush;

  modport store (input in_valid, in_data, out_ready, flush,
                 output in_ready, out_valid, out_data, count);
  modport user  (output in_valid, in_data, out_ready, flush,
                 input in_ready, out_valid, out_data, count);
endinterface

// ### hdl/ufh_pkg.sv
package ufh_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 5;
  localparam int MASK_W     = 4;

  // ----------------------------------------------------------------
  // Register addresses on host_addr
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_HOLDING     = 3'h0;  // rx_holding read, tx_holding write
  localparam logic [2:0] ADDR_MASK        = 3'h1;  // interrupt_mask
  localparam logic [2:0] ADDR_FIFO_CTRL   = 3'h2;  // fifo_control write, interrupt_status read
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;  // line_status read

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FC_ENABLE   = 0;
  localparam int FC_RX_FLUSH = 1;
  localparam int FC_TX_FLUSH = 2;
  localparam int FC_DMA_MODE = 3;
  localparam int FC_TRIG_LSB = 6;
  localparam int IM_RX       = 0;
  localparam int IM_TX       = 1;
  localparam int IM_LINE     = 2;
  localparam int IM_MODEM    = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [MASK_W-1:0] MASK_RESET = 4'h0;
  localparam logic [1:0]        TRIG_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Interrupt status codes, bits 3:0
  // ----------------------------------------------------------------
  localparam logic [3:0] ISR_NONE    = 4'h1;
  localparam logic [3:0] ISR_LINE    = 4'h6;
  localparam logic [3:0] ISR_RX_READY_N   = 4'h4;
  localparam logic [3:0] ISR_TIMEOUT = 4'hc;
  localparam logic [3:0] ISR_THRE    = 4'h2;
  localparam logic [3:0] ISR_MODEM   = 4'h0;

  // ----------------------------------------------------------------
  // Receive trigger levels in characters
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] TRIG_1  = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_4  = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_8  = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_14 = 5'h0e;

  // ----------------------------------------------------------------
  // Serial timing in 16x ticks
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST_TICK     = 4'hf;   // 16 ticks per bit
  localparam logic [3:0] START_SAMPLE_TICK = 4'h7;   // 8th tick, about 7.5 into start bit
  localparam logic [2:0] DATA_LAST_BIT     = 3'h7;
  localparam logic [3:0] TX_LAST_BIT       = 4'h9;   // start, 8 data, stop
  localparam logic [9:0] TIMEOUT_TICKS     = 10'h280; // four character times

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } ufh_rx_state_t;

endpackage

// ### hdl/ufh_uart.sv
// How it works
// - 8-bit transmit holding feeds shifter; write loads only if holding has room.
// - Holding-empty flag sets when transmit queue is flushed or its last byte moves to shifter.
// - Reading receive holding pops the oldest received byte.
// - Falling edge starts 16x count; start validated only if line low at centre.
// - Mask bits 0-3 gate rx, tx-empty, line, modem sources; bits 7:4 read zero.
// - Rx data interrupt while fill is at or above trigger level.
// - Interrupt status shows trigger condition while it holds, clears with it.
// - Data-ready sets when a character enters the queue, clears when empty.
// - Line status: bit5 tx queue empty, bit6 all empty, bit7 framing error with queues on.
// - Control bit 0 enables queues; other bits change only if bit 0 written 1.
// - Control bit 1 flushes receive queue, shifter untouched, bit self-clears.
// - Control bit 2 flushes transmit queue, shifter untouched, bit self-clears.
// - Control bit 3 picks ready-pin mode; mode 1 only with queues enabled.
// - Mode 0: tx_ready_n low while nothing held, high once a byte is loaded.
// - Mode 0: rx_ready_n low while a received byte is held.
// - Mode 1: tx_ready_n high only when transmit queue is full.
// - Mode 1: rx_ready_n low on trigger or timeout, high again when empty.
// - Trigger code 00 gives 1, 10 gives 8, 11 gives 14; queue keeps filling.
// - Receive timeout reported as its own interrupt status code, ranked below rx data.
// - Byte arriving to a full queue flags overrun and is dropped.
`timescale 1ns/1ps
module ufh_uart (
  input  wire logic       core_clk,             // System clock, 100 MHz
  input  wire logic       rst,                  // Asynchronous reset, active high
  input  wire logic [2:0] host_addr,            // Register select
  input  wire logic       host_cs,              // Chip select
  input  wire logic       host_rd,              // Read strobe, one cycle
  input  wire logic       host_wr,              // Write strobe, one cycle
  input  wire logic [7:0] host_data_bus_in,     // Write data
  output logic      [7:0] host_data_bus_out,    // Read data
  output logic            host_data_bus_oe,     // Read data drive enable
  input  wire logic       tick16,               // 16x baud tick, one cycle
  input  wire logic       rx_line,              // Serial input
  output logic            tx_line,              // Serial output
  input  wire logic       modem_event,          // Modem status change pending
  output logic            irq,                  // Interrupt, active high
  output logic            tx_ready_n,           // Transmit ready, active low
  output logic            rx_ready_n            // Receive ready, active low
);

  // ----------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------
  // One queue module serves both sides; a flush never reaches a shifter byte
  ufh_fifo_if #(.WIDTH(ufh_pkg::DATA_W), .DEPTH(ufh_pkg::FIFO_DEPTH)) txq ();
  ufh_fifo_if #(.WIDTH(ufh_pkg::DATA_W), .DEPTH(ufh_pkg::FIFO_DEPTH)) rxq ();

  ufh_fifo #(.WIDTH(ufh_pkg::DATA_W), .DEPTH(ufh_pkg::FIFO_DEPTH)) u_txq (
    .core_clk (core_clk),
    .rst      (rst),
    .fq       (txq.store)
  );

  ufh_fifo #(.WIDTH(ufh_pkg::DATA_W), .DEPTH(ufh_pkg::FIFO_DEPTH)) u_rxq (
    .core_clk (core_clk),
    .rst      (rst),
    .fq       (rxq.store)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [ufh_pkg::MASK_W-1:0] mask_reg;
  logic                       fifo_en_reg;
  logic                       dma_mode_reg;
  logic [1:0]                 trig_reg;
  logic                       overrun_reg;
  logic                       framing_reg;
  logic                       timeout_reg;
  logic [9:0]                 idle_cnt_reg;
  logic                       rx_dma_act_reg;

  function automatic logic [ufh_pkg::CNT_W-1:0] trig_level(input logic [1:0] code);
    unique case (code)
      2'b00: trig_level = ufh_pkg::TRIG_1;
      2'b01: trig_level = ufh_pkg::TRIG_4;
      2'b10: trig_level = ufh_pkg::TRIG_8;
      2'b11: trig_level = ufh_pkg::TRIG_14;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------
  wire hold_wr   = host_cs & host_wr & (host_addr == ufh_pkg::ADDR_HOLDING);
  wire mask_wr   = host_cs & host_wr & (host_addr == ufh_pkg::ADDR_MASK);
  wire fctl_wr   = host_cs & host_wr & (host_addr == ufh_pkg::ADDR_FIFO_CTRL);
  wire hold_rd   = host_cs & host_rd & (host_addr == ufh_pkg::ADDR_HOLDING);
  wire status_rd = host_cs & host_rd & (host_addr == ufh_pkg::ADDR_LINE_STATUS);
  wire any_rd    = host_cs & host_rd;
  // Unmapped addresses read zero and ignore writes

  wire wr_en_bit = host_data_bus_in[ufh_pkg::FC_ENABLE];
  // Switching the queues on or off also empties them, as a mode change
  // would otherwise leave stale bytes counted against the wrong depth.
  wire en_change = fctl_wr & (wr_en_bit != fifo_en_reg);
  wire rx_flush  = en_change |
                   (fctl_wr & wr_en_bit & host_data_bus_in[ufh_pkg::FC_RX_FLUSH]);
  wire tx_flush  = en_change |
                   (fctl_wr & wr_en_bit & host_data_bus_in[ufh_pkg::FC_TX_FLUSH]);

  // ----------------------------------------------------------------
  // Queue status
  // ----------------------------------------------------------------
  wire                       tx_empty = (txq.count == '0);
  wire                       rx_empty = (rxq.count == '0);
  // Without queues each side holds one byte only
  wire                       tx_room  = fifo_en_reg ? txq.in_ready : tx_empty;
  wire                       rx_room  = fifo_en_reg ? rxq.in_ready : rx_empty;
  wire                       dma_one  = fifo_en_reg & dma_mode_reg;
  // With queues off the trigger is one byte, so the receive interrupt
  // behaves as a plain data-ready source
  wire [ufh_pkg::CNT_W-1:0]  level    = fifo_en_reg ? trig_level(trig_reg) : ufh_pkg::TRIG_1;
  wire                       trig_hit = (rxq.count >= level);

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic [9:0] tx_shift_reg;
  logic       tx_busy_reg;
  logic [3:0] tx_tick_reg;
  logic [3:0] tx_bit_reg;

  assign txq.in_valid  = hold_wr & tx_room;
  assign txq.in_data   = host_data_bus_in;
  assign txq.flush     = tx_flush;
  assign txq.out_ready = ~tx_busy_reg;

  wire tx_load     = txq.out_valid & ~tx_busy_reg;
  wire tx_bit_end  = tx_busy_reg & tick16 & (tx_tick_reg == ufh_pkg::BIT_LAST_TICK);
  wire tx_last_bit = (tx_bit_reg == ufh_pkg::TX_LAST_BIT);
  // The shifter takes the next byte the cycle after it frees, so a full
  // queue drains with one idle-high cycle between stop and start bits

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= '1;
      tx_tick_reg  <= '0;
      tx_bit_reg   <= '0;
    end else if (tx_load) begin
      tx_busy_reg  <= 1'b1;
      tx_shift_reg <= {1'b1, txq.out_data, 1'b0};
      tx_tick_reg  <= '0;
      tx_bit_reg   <= '0;
    end else if (tx_busy_reg && tick16) begin
      tx_tick_reg <= tx_tick_reg + 1'b1;
      if (tx_bit_end) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bit_reg   <= tx_bit_reg + 1'b1;
        tx_busy_reg  <= ~tx_last_bit;
      end
    end
  end

  assign tx_line = tx_busy_reg ? tx_shift_reg[0] : 1'b1;

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  ufh_pkg::ufh_rx_state_t rx_state_reg;
  logic                   rx_prev_reg;
  logic [3:0]             rx_tick_reg;
  logic [2:0]             rx_bit_reg;
  logic [7:0]             rx_shift_reg;

  // Start edge is found against the previous cycle; the line is taken as synchronous
  wire rx_fall     = rx_prev_reg & ~rx_line;
  wire rx_centre   = tick16 & (rx_tick_reg == ufh_pkg::START_SAMPLE_TICK);
  wire rx_bit_end  = tick16 & (rx_tick_reg == ufh_pkg::BIT_LAST_TICK);
  wire rx_stop_end = (rx_state_reg == ufh_pkg::RX_STOP) & rx_bit_end;
  wire rx_push     = rx_stop_end & rx_room;
  wire rx_overrun  = rx_stop_end & ~rx_room;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= ufh_pkg::RX_IDLE;
      rx_prev_reg  <= 1'b1;
      rx_tick_reg  <= '0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= '0;
    end else begin
      rx_prev_reg <= rx_line;
      if (tick16) rx_tick_reg <= rx_tick_reg + 1'b1;
      unique case (rx_state_reg)
        ufh_pkg::RX_IDLE: begin
          rx_tick_reg <= '0;
          if (rx_fall) rx_state_reg <= ufh_pkg::RX_START;
        end
        ufh_pkg::RX_START: begin
          if (rx_centre) begin
            rx_tick_reg  <= '0;
            rx_bit_reg   <= '0;
            // A glitch that is gone by the centre is dropped
            rx_state_reg <= rx_line ? ufh_pkg::RX_IDLE : ufh_pkg::RX_DATA;
          end
        end
        ufh_pkg::RX_DATA: begin
          if (rx_bit_end) begin
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == ufh_pkg::DATA_LAST_BIT) rx_state_reg <= ufh_pkg::RX_STOP;
          end
        end
        ufh_pkg::RX_STOP: begin
          if (rx_bit_end) rx_state_reg <= ufh_pkg::RX_IDLE;
        end
        // A corrupted one-hot code falls back to idle and waits for a start
        default: rx_state_reg <= ufh_pkg::RX_IDLE;
      endcase
    end
  end

  assign rxq.in_valid  = rx_push;
  assign rxq.in_data   = rx_shift_reg;
  assign rxq.flush     = rx_flush;
  assign rxq.out_ready = hold_rd;

  // ----------------------------------------------------------------
  // Receive timeout and error flags
  // ----------------------------------------------------------------
  // Any push or pop restarts the wait; only a resting queue times out.
  wire idle_restart = rx_empty | rx_push | hold_rd;
  wire timeout_hit  = ~idle_restart & tick16 & (idle_cnt_reg == ufh_pkg::TIMEOUT_TICKS);
  // The counter parks at its end value, so the flag holds until data moves.
  // A holding read restarts the wait even when it pops nothing.

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_cnt_reg <= '0;
      timeout_reg  <= 1'b0;
    end else begin
      if (idle_restart) idle_cnt_reg <= '0;
      else if (tick16 && !timeout_hit) idle_cnt_reg <= idle_cnt_reg + 1'b1;
      timeout_reg <= timeout_hit | (timeout_reg & ~idle_restart);
    end
  end

  // Set wins over the clear by a line status read in the same cycle
  wire framing_set = rx_stop_end & ~rx_line;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overrun_reg <= 1'b0;
      framing_reg <= 1'b0;
    end else begin
      overrun_reg <= rx_overrun | (overrun_reg & ~status_rd);
      framing_reg <= framing_set | (framing_reg & ~status_rd);
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // A control write with enable low only turns the queues off; mode and
  // trigger keep their last values for the next enabling write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_reg     <= ufh_pkg::MASK_RESET;
      fifo_en_reg  <= 1'b0;
      dma_mode_reg <= 1'b0;
      trig_reg     <= ufh_pkg::TRIG_RESET;
    end else begin
      if (mask_wr) mask_reg <= host_data_bus_in[ufh_pkg::MASK_W-1:0];
      if (fctl_wr) begin
        fifo_en_reg <= wr_en_bit;
        if (wr_en_bit) begin
          dma_mode_reg <= host_data_bus_in[ufh_pkg::FC_DMA_MODE];
          trig_reg     <= host_data_bus_in[ufh_pkg::FC_TRIG_LSB +: 2];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt priority
  // ----------------------------------------------------------------
  // Sources are live levels; reading the status code clears none of them,
  // so software removes each cause at its origin
  wire line_src  = mask_reg[ufh_pkg::IM_LINE] & (overrun_reg | framing_reg);
  wire rx_src    = mask_reg[ufh_pkg::IM_RX] & trig_hit;
  wire tout_src  = mask_reg[ufh_pkg::IM_RX] & timeout_reg & fifo_en_reg;
  wire thre_src  = mask_reg[ufh_pkg::IM_TX] & tx_empty;
  wire modem_src = mask_reg[ufh_pkg::IM_MODEM] & modem_event;

  wire [3:0] isr_code = line_src  ? ufh_pkg::ISR_LINE    :
                        rx_src    ? ufh_pkg::ISR_RX_READY_N   :
                        tout_src  ? ufh_pkg::ISR_TIMEOUT :
                        thre_src  ? ufh_pkg::ISR_THRE    :
                        modem_src ? ufh_pkg::ISR_MODEM   : ufh_pkg::ISR_NONE;

  assign irq = ~isr_code[0];

  // ----------------------------------------------------------------
  // Ready pins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_dma_act_reg <= 1'b0;
    end else begin
      // Trigger or timeout set wins over the empty clear
      rx_dma_act_reg <= trig_hit | timeout_reg | (rx_dma_act_reg & ~rx_empty);
    end
  end

  // The mode 1 receive pin is latched so it stays low while the host
  // drains below the trigger; it lets go one cycle after the queue empties
  assign tx_ready_n = dma_one ? ~txq.in_ready : ~tx_empty;
  assign rx_ready_n = dma_one ? ~rx_dma_act_reg : rx_empty;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] line_status = {fifo_en_reg & framing_reg,
                            tx_empty & ~tx_busy_reg,
                            tx_empty,
                            1'b0,
                            framing_reg,
                            1'b0,
                            overrun_reg,
                            ~rx_empty};
  wire [7:0] isr_value   = {fifo_en_reg, fifo_en_reg, 2'b00, isr_code};
  wire [7:0] mask_value  = {4'h0, mask_reg};

  // Read data is captured at the strobe, so a pop in the same cycle never
  // changes the byte the host sees
  wire [7:0] rd_mux = (host_addr == ufh_pkg::ADDR_HOLDING)     ? rxq.out_data :
                      (host_addr == ufh_pkg::ADDR_MASK)        ? mask_value   :
                      (host_addr == ufh_pkg::ADDR_FIFO_CTRL)   ? isr_value    :
                      (host_addr == ufh_pkg::ADDR_LINE_STATUS) ? line_status  : 8'h00;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_data_bus_out <= 8'h00;
      host_data_bus_oe  <= 1'b0;
    end else begin
      host_data_bus_oe <= any_rd;
      if (any_rd) host_data_bus_out <= rd_mux;
    end
  end

endmodule
